// File: verilog/sdd_consts.svh
// constants for the serial display driver core
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

`define SDD_WIDTH 32
`define SDD_SYNC_RESET 1'h0
`define SDD_CLK_PERIOD_NS 40
`define SDD_T_CDO_NS 500
`define SDD_T_CDO_CYC (`SDD_T_CDO_NS / `SDD_CLK_PERIOD_NS)

`endif

// File: verilog/sdd_pkg.sv
// types for the serial display driver core
`include "sdd_consts.svh"

package sdd_pkg;

   typedef logic [`SDD_WIDTH-1:0] sdd_word_t;

   typedef struct packed {
      logic shift_clk;
      logic ser_in;
      logic enable;
      logic blank;
   } sdd_pins_s;

endpackage : sdd_pkg

// File: verilog/sdd_core.sv
// serial-in display driver core: shift register, output latches, blanking, cascade output
`timescale 1ns/1ps
`default_nettype none
`include "sdd_consts.svh"

module sdd_core (
   input wire logic clock,
   input wire logic rst_b,
   input wire sdd_pkg::sdd_pins_s pins,
   output logic [`SDD_WIDTH-1:0] seg_on,
   output logic ser_out
);
   import sdd_pkg::*;

   // plain int so the delay range below has a bound the tools can fold
   localparam int T_CDO_CYC = `SDD_T_CDO_CYC;

   sdd_pins_s meta_r;
   sdd_pins_s sync_r;
   logic clk_d_r;
   logic en_d_r;
   sdd_word_t shift_r;
   sdd_word_t latch_r;
   sdd_word_t seg_r;
   logic dout_r;
   logic clk_rise;
   logic clk_fall;
   logic en_fall;

   // pins come from the host's domain: two flops before any logic looks at them
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clk_d_r <= `SDD_SYNC_RESET;
         en_d_r <= `SDD_SYNC_RESET;
      end else begin
         clk_d_r <= sync_r.shift_clk;
         en_d_r <= sync_r.enable;
      end
   end

   assign clk_rise = sync_r.shift_clk & ~clk_d_r;
   assign clk_fall = ~sync_r.shift_clk & clk_d_r;
   assign en_fall = ~sync_r.enable & en_d_r;

   // data is synchronised alongside the clock, so it is sampled with the same
   // latency as the edge it was set up against
   // storage is deliberately left out of reset, as on the real part
   always_ff @(posedge clock) begin
      if (clk_rise && sync_r.enable) begin
         shift_r <= {sync_r.ser_in, shift_r[`SDD_WIDTH-1:1]};
      end
   end

   always_ff @(posedge clock) begin
      if (en_fall) begin
         latch_r <= shift_r;
      end
   end

   // falling edges move the cascade output whether or not enable is still high,
   // since the host may drop enable before the last falling edge
   always_ff @(posedge clock) begin
      if (clk_fall) begin
         dout_r <= shift_r[0];
      end
   end

   // bit 0 is output one; blanking overrides the pattern, enable plays no part
   always_ff @(posedge clock) begin
      seg_r <= sync_r.blank ? '0 : latch_r;
   end

   assign seg_on = seg_r;
   assign ser_out = dout_r;

   a_shift_rise: assert property (@(posedge clock) disable iff (!rst_b)
      clk_rise && sync_r.enable |=>
         shift_r === {$past(sync_r.ser_in), $past(shift_r[`SDD_WIDTH-1:1])})
      else $error("shift register did not take the input bit");

   a_shift_gated: assert property (@(posedge clock) disable iff (!rst_b)
      !(clk_rise && sync_r.enable) |=> shift_r === $past(shift_r))
      else $error("shift register moved without an enabled rising edge");

   a_latch_load: assert property (@(posedge clock) disable iff (!rst_b)
      en_fall |=> latch_r == $past(shift_r))
      else $error("latches did not load on enable falling");

   a_latch_hold: assert property (@(posedge clock) disable iff (!rst_b)
      sync_r.enable |=> latch_r === $past(latch_r))
      else $error("latches changed during a transfer");

   a_dout_fall: assert property (@(posedge clock) disable iff (!rst_b)
      clk_fall |=> ser_out === $past(shift_r[0]))
      else $error("serial output missed the falling edge");

   a_dout_steady: assert property (@(posedge clock) disable iff (!rst_b)
      !clk_fall |=> ser_out === $past(ser_out))
      else $error("serial output changed away from a falling edge");

   a_seg_map: assert property (@(posedge clock) disable iff (!rst_b)
      !sync_r.blank |=> seg_on === $past(latch_r))
      else $error("outputs do not follow the latched pattern");

   a_blank_off: assert property (@(posedge clock) disable iff (!rst_b)
      sync_r.blank |=> seg_on == '0)
      else $error("outputs not forced off while blanked");

   a_blank_indep: assert property (@(posedge clock) disable iff (!rst_b)
      en_fall && sync_r.blank |=> latch_r == $past(shift_r) && seg_on == '0)
      else $error("blanking disturbed the latch load");

   a_first_bit: assert property (@(posedge clock) disable iff (!rst_b)
      clk_rise && sync_r.enable |=> shift_r[`SDD_WIDTH-1] == $past(sync_r.ser_in))
      else $error("new bit did not enter at the top stage");

   a_cdo_bound: assert property (@(posedge clock) disable iff (!rst_b)
      $fell(pins.shift_clk) ##0 sync_r.enable ##1 !pins.shift_clk [*3] |->
         ##[0:T_CDO_CYC] ser_out === shift_r[0])
      else $error("serial output later than the clock-to-data time");

endmodule : sdd_core
`default_nettype wire

// File: tb/sdd_host.sv
// host model that drives the display driver pins
`timescale 1ns/1ps
`default_nettype none
`include "sdd_consts.svh"
module sdd_host (
   input wire logic clock,
   output var sdd_pkg::sdd_pins_s pins
);
   import sdd_pkg::*;
   initial pins = '0;
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask : wait_n
   // bit 0 goes first so it lands on output one
   task automatic frame(input sdd_word_t w, input logic en);
      pins.enable = en;
      wait_n(4);
      for (int i = 0; i < `SDD_WIDTH; i++) begin
         pins.ser_in = w[i];
         wait_n(4);
         pins.shift_clk = 1'h1;
         wait_n(8);
         pins.shift_clk = 1'h0;
         wait_n(2);
         // data line after hold is not left showing the old bit
         pins.ser_in = ~w[i];
         wait_n(2);
      end
      pins.enable = 1'h1;
      wait_n(4);
      pins.enable = 1'h0;
      wait_n(8);
   endtask : frame
endmodule : sdd_host
`default_nettype wire

// File: tb/tb_sdd_core.sv
// testbench for the serial display driver core
`timescale 1ns/1ps
`default_nettype none
module tb_sdd_core;
   import sdd_pkg::*;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   sdd_pins_s pins;
   sdd_word_t seg_on;
   logic ser_out;
   sdd_word_t shown;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   always #20 clock = ~clock;
   sdd_host host (.clock(clock), .pins(pins));
   sdd_core dut_u (.clock(clock), .rst_b(rst_b), .pins(pins), .seg_on(seg_on),
      .ser_out(ser_out));
   task automatic check(input string name, input sdd_word_t seen, input sdd_word_t exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // waits 300 cycles into the 528-cycle frame so the old pattern is checked mid transfer
   task automatic t_load(input sdd_word_t w);
      fork
         host.frame(w, 1'h1);
         begin
            host.wait_n(300);
            check("seg_on held", seg_on, shown);
         end
      join
      check("seg_on", seg_on, w);
      check("ser_out", {31'h0, ser_out}, {31'h0, w[0]});
      shown = w;
   endtask : t_load
   task automatic t_ignore;
      host.frame(32'hFFFF_FFFF, 1'h0);
      check("seg_on ignored", seg_on, shown);
      check("ser_out kept", {31'h0, ser_out}, {31'h0, shown[0]});
   endtask : t_ignore
   task automatic t_blank(input sdd_word_t w);
      host.pins.blank = 1'h1;
      host.wait_n(6);
      check("blanked", seg_on, 32'h0);
      host.frame(w, 1'h1);
      check("blanked load", seg_on, 32'h0);
      host.pins.blank = 1'h0;
      host.wait_n(6);
      check("unblanked", seg_on, w);
      shown = w;
   endtask : t_blank
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      host.wait_n(2);
      rst_b = 1'h1;
      host.frame(32'h0, 1'h1);
      check("cleared", seg_on, 32'h0);
      shown = 32'h0;
      t_load(32'h8000_0001);
      t_load(32'hA5C3_0F96);
      t_ignore();
      t_blank(32'h1234_5678);
      complete_run();
   end
endmodule : tb_sdd_core
`default_nettype wire
